// File: hw/stc_clock_trim.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// Sampling and timing clock trim block
module stc_clock_trim
  import stc_pkg::*;
#(
  parameter logic [15:0] SAMPLE_RATE_RST = RST_SAMPLE_RATE  // Divider default
) (
  // Clock, reset and clock enable
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Register port
  input  wire stc_req_s    bus_req,
  output logic [15:0]      rd_data,
  // Auxiliary pin, external sampling clock
  input  wire logic        auxiliary_pin,
  // Clock edges out
  output stc_ticks_s       ticks,
  // Levels out
  output logic             sampling_clk,
  output logic             sampling_src_ext,
  output logic [15:0]      conv_clock_code
);

  //============================================================================
  // Register storage
  logic [15:0] samp_cfg_q;      // Sampling clock config
  logic [15:0] samp_cfg_d;
  logic [15:0] tim_trim_q;      // Timing trim register
  logic [15:0] tim_trim_d;
  logic [15:0] conv_sel_q;      // Converter clock select
  logic [15:0] conv_sel_d;
  logic [15:0] trig_cfg_q;      // Trigger config
  logic [15:0] trig_cfg_d;
  logic [15:0] rate_q;          // Sample rate divider
  logic [15:0] rate_d;
  logic [15:0] rd_data_q;       // Read data, one cycle after strobe
  logic [15:0] rd_data_d;

  //============================================================================
  // Decoded fields
  logic                  sampling_osc_bypass;     // External source select
  logic                  sampling_clock_enable;   // Sampling clock gate
  logic [TRIM_S_W-1:0]   sampling_osc_trim;       // Sampling trim code
  logic [TRIM_T_W-1:0]   timing_osc_trim;         // Timing trim code
  logic [1:0]            sample_trigger_select;   // Trigger source
  logic                  conv_fast;               // Converter at 1 MHz

  //============================================================================
  // Clock generation state
  logic        aux_prev_q;      // Auxiliary pin, previous sample
  logic        aux_prev_d;
  logic        ext_edge;        // Rising edge on auxiliary pin
  logic        int_edge;        // Internal sampling oscillator edge
  logic        samp_edge;       // Selected sampling edge, ungated
  logic        samp_tick_q;     // Gated sampling edge
  logic        samp_tick_d;
  logic        samp_lvl_q;      // Sampling clock square wave
  logic        samp_lvl_d;
  logic [31:0] samp_hz;         // Trimmed sampling frequency
  logic [31:0] tim_hz;          // Trimmed timing frequency
  logic [31:0] conv_hz;         // Selected converter frequency
  logic        tim_edge;        // Timing oscillator edge
  logic        conv_edge;       // Converter clock edge

  //============================================================================
  // Sample pacing state
  logic [15:0] pace_cnt_q;      // Sampling edges since last start
  logic [15:0] pace_cnt_d;
  logic        start_q;         // Sample start pulse
  logic        start_d;
  logic [15:0] pace_last;       // Terminal count

  //============================================================================
  // Field decode
  assign sampling_osc_bypass   = samp_cfg_q[BIT_BYPASS];
  assign sampling_clock_enable = samp_cfg_q[BIT_SAMP_EN];
  assign sampling_osc_trim     = samp_cfg_q[TRIM_S_LSB +: TRIM_S_W];
  assign timing_osc_trim       = tim_trim_q[TRIM_T_LSB +: TRIM_T_W];
  assign sample_trigger_select = trig_cfg_q[TRIG_SEL_LSB +: 2];
  assign conv_fast             = (conv_sel_q == CONV_CODE_FAST);

  //============================================================================
  // Register writes and reads
  always_comb begin
    samp_cfg_d = samp_cfg_q;
    tim_trim_d = tim_trim_q;
    conv_sel_d = conv_sel_q;
    trig_cfg_d = trig_cfg_q;
    rate_d     = rate_q;
    rd_data_d  = '0;
    // Write decode; reserved bits stored as written
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_SAMP_CFG:    samp_cfg_d = bus_req.wdata;
        OFS_TIM_TRIM:    tim_trim_d = bus_req.wdata;
        OFS_CONV_SEL:    conv_sel_d = bus_req.wdata;
        OFS_TRIG_CFG:    trig_cfg_d = bus_req.wdata;
        OFS_SAMPLE_RATE: rate_d     = bus_req.wdata;
        default: begin
          // Unmapped or status address: write ignored
        end
      endcase
    end
    // Read decode; unmapped reads return zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_SAMP_CFG:    rd_data_d = samp_cfg_q;
        OFS_TIM_TRIM:    rd_data_d = tim_trim_q;
        OFS_CONV_SEL:    rd_data_d = conv_sel_q;
        OFS_TRIG_CFG:    rd_data_d = trig_cfg_q;
        OFS_SAMPLE_RATE: rd_data_d = rate_q;
        OFS_STATUS: begin
          rd_data_d[ST_EXT_SRC]   = sampling_osc_bypass;
          rd_data_d[ST_SAMP_RUN]  = sampling_clock_enable;
          rd_data_d[ST_CONV_FAST] = conv_fast;
          rd_data_d[ST_TRIG_INT]  = (sample_trigger_select == TRIG_INTERNAL);
        end
        default: begin
          rd_data_d = '0;
        end
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      samp_cfg_q <= RST_SAMP_CFG;
      tim_trim_q <= RST_TIM_TRIM;
      conv_sel_q <= RST_CONV_SEL;
      trig_cfg_q <= RST_TRIG_CFG;
      rate_q     <= SAMPLE_RATE_RST;
      rd_data_q  <= '0;
    end else if (clk_en) begin
      samp_cfg_q <= samp_cfg_d;
      tim_trim_q <= tim_trim_d;
      conv_sel_q <= conv_sel_d;
      trig_cfg_q <= trig_cfg_d;
      rate_q     <= rate_d;
      rd_data_q  <= rd_data_d;
    end
  end

  //============================================================================
  // Trimmed frequencies
  // Sampling: larger code gives lower frequency, centre code at nominal
  assign samp_hz = trim_freq(SAMP_NOM_HZ, SAMP_STEP_HZ,
                             8'(sampling_osc_trim), SAMP_CENTRE, 1'b1);
  // Timing: larger code gives higher frequency, default code at nominal
  assign tim_hz  = trim_freq(TIM_NOM_HZ, TIM_STEP_HZ,
                             timing_osc_trim, TIM_CENTRE, 1'b0);
  // Converter: undefined codes fall back to the slow rate
  assign conv_hz = conv_fast ? CONV_FAST_HZ : CONV_SLOW_HZ;

  //============================================================================
  // Internal sampling oscillator; held at zero phase while bypassed or off
  stc_nco #(
    .ACC_W   (32),
    .MODULUS (CLK_HZ)
  ) u_samp_osc (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .run     (sampling_clock_enable && !sampling_osc_bypass),
    .incr    (samp_hz),
    .tick    (int_edge)
  );

  // Fast timing oscillator for pulse timing, always running
  stc_nco #(
    .ACC_W   (32),
    .MODULUS (CLK_HZ)
  ) u_tim_osc (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .run     (1'b1),
    .incr    (tim_hz),
    .tick    (tim_edge)
  );

  // Converter clock generator
  stc_nco #(
    .ACC_W   (32),
    .MODULUS (CLK_HZ)
  ) u_conv_osc (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .run     (1'b1),
    .incr    (conv_hz),
    .tick    (conv_edge)
  );

  //============================================================================
  // Sampling source select and gate
  assign ext_edge  = auxiliary_pin && !aux_prev_q;
  assign samp_edge = sampling_osc_bypass ? ext_edge : int_edge;

  always_comb begin
    aux_prev_d  = auxiliary_pin;
    samp_tick_d = sampling_clock_enable && samp_edge;
    samp_lvl_d  = samp_lvl_q;
    // Square wave toggles on each gated edge, parks low when stopped
    if (!sampling_clock_enable) begin
      samp_lvl_d = 1'b0;
    end else if (samp_edge) begin
      samp_lvl_d = !samp_lvl_q;
    end
  end

  // Sampling clock flops
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aux_prev_q  <= 1'b0;
      samp_tick_q <= 1'b0;
      samp_lvl_q  <= 1'b0;
    end else if (clk_en) begin
      aux_prev_q  <= aux_prev_d;
      samp_tick_q <= samp_tick_d;
      samp_lvl_q  <= samp_lvl_d;
    end
  end

  //============================================================================
  // Internal sample pacing from the sampling clock and divider
  assign pace_last = (rate_q == '0) ? '0 : rate_q - 16'h0001;

  always_comb begin
    pace_cnt_d = pace_cnt_q;
    start_d    = 1'b0;
    // Pacing only in internal trigger mode, counter idles otherwise
    if (sample_trigger_select != TRIG_INTERNAL) begin
      pace_cnt_d = '0;
    end else if (samp_tick_q) begin
      if (pace_cnt_q >= pace_last) begin
        pace_cnt_d = '0;
        start_d    = 1'b1;
      end else begin
        pace_cnt_d = pace_cnt_q + 16'h0001;
      end
    end
  end

  // Pacing flops
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pace_cnt_q <= '0;
      start_q    <= 1'b0;
    end else if (clk_en) begin
      pace_cnt_q <= pace_cnt_d;
      start_q    <= start_d;
    end
  end

  //============================================================================
  // Outputs
  assign rd_data            = rd_data_q;
  assign ticks.samp_tick    = samp_tick_q;
  assign ticks.tim_tick     = tim_edge;
  assign ticks.conv_tick    = conv_edge;
  assign ticks.sample_start = start_q;
  assign sampling_clk       = samp_lvl_q;
  assign sampling_src_ext   = sampling_osc_bypass;
  assign conv_clock_code    = conv_sel_q;

endmodule
`default_nettype wire

// File: hw/stc_nco.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// Numerically controlled edge generator
module stc_nco
  import stc_pkg::*;
#(
  parameter int unsigned ACC_W   = 32,      // Accumulator width
  parameter int unsigned MODULUS = CLK_HZ   // Wrap value, system clock rate
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Control
  input  wire logic             run,
  input  wire logic [ACC_W-1:0] incr,
  // Output
  output logic                  tick
);

  localparam logic [ACC_W:0] MOD_EXT = (ACC_W+1)'(MODULUS);  // Wrap, one bit wider

  logic [ACC_W-1:0] acc_q;   // Phase accumulator
  logic [ACC_W-1:0] acc_d;
  logic             tick_q;  // Registered edge pulse
  logic             tick_d;
  logic [ACC_W:0]   sum;     // Unwrapped next phase

  //============================================================================
  // Next phase; a stopped generator restarts from zero phase
  always_comb begin
    sum    = {1'b0, acc_q} + {1'b0, incr};
    acc_d  = acc_q;
    tick_d = 1'b0;
    if (!run) begin
      acc_d = '0;
    end else if (sum >= MOD_EXT) begin
      acc_d  = ACC_W'(sum - MOD_EXT);
      tick_d = 1'b1;
    end else begin
      acc_d = sum[ACC_W-1:0];
    end
  end

  //============================================================================
  // Registers, frozen while clock enable is low
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// File: hw/stc_pkg.sv
//==============================================================================
//==============================================================================
package stc_pkg;

  //============================================================================
  // Register bus shape
  localparam int unsigned ADDR_W = 8;     // Register address width
  localparam int unsigned DATA_W = 16;    // Register data width

  //============================================================================
  // Register offsets
  localparam logic [7:0] OFS_SAMPLE_RATE = 8'h12;  // Sample rate divider
  localparam logic [7:0] OFS_SAMP_CFG    = 8'h4B;  // Sampling clock config
  localparam logic [7:0] OFS_TIM_TRIM    = 8'h4D;  // Timing oscillator trim
  localparam logic [7:0] OFS_CONV_SEL    = 8'h4E;  // Converter clock select
  localparam logic [7:0] OFS_TRIG_CFG    = 8'h4F;  // Sample trigger config
  localparam logic [7:0] OFS_STATUS      = 8'h7F;  // Clock status, read only

  //============================================================================
  // Field positions
  localparam int unsigned BIT_BYPASS    = 8;  // Sampling oscillator bypass
  localparam int unsigned BIT_SAMP_EN   = 7;  // Sampling clock enable
  localparam int unsigned TRIM_S_LSB    = 0;  // Sampling trim field low bit
  localparam int unsigned TRIM_S_W      = 6;  // Sampling trim width
  localparam int unsigned TRIM_T_LSB    = 0;  // Timing trim field low bit
  localparam int unsigned TRIM_T_W      = 8;  // Timing trim width
  localparam int unsigned TRIG_SEL_LSB  = 2;  // Trigger select low bit
  localparam int unsigned ST_EXT_SRC    = 0;  // Status: external source
  localparam int unsigned ST_SAMP_RUN   = 1;  // Status: sampling clock runs
  localparam int unsigned ST_CONV_FAST  = 2;  // Status: converter at 1 MHz
  localparam int unsigned ST_TRIG_INT   = 3;  // Status: internal pacing

  //============================================================================
  // Reset values
  localparam logic [15:0] RST_SAMP_CFG    = 16'h2612;
  localparam logic [15:0] RST_TIM_TRIM    = 16'h425E;
  localparam logic [15:0] RST_CONV_SEL    = 16'h0060;
  localparam logic [15:0] RST_TRIG_CFG    = 16'h2090;
  localparam logic [15:0] RST_SAMPLE_RATE = 16'h0140;

  //============================================================================
  // Codes
  localparam logic [15:0] CONV_CODE_FAST = 16'h0040;  // 1 MHz
  localparam logic [15:0] CONV_CODE_SLOW = 16'h0060;  // 500 kHz
  localparam logic [1:0]  TRIG_INTERNAL  = 2'h0;      // Internal pacing
  localparam logic [7:0]  SAMP_CENTRE    = 8'h22;     // Typical centre code
  localparam logic [7:0]  TIM_CENTRE     = 8'h5E;     // Default timing code

  //============================================================================
  // Frequencies in hertz
  localparam int unsigned CLK_HZ        = 125_000_000;  // System clock
  localparam int unsigned SAMP_NOM_HZ   = 32_000;       // Sampling nominal
  localparam int unsigned SAMP_STEP_HZ  = 600;          // Sampling step
  localparam int unsigned TIM_NOM_HZ    = 32_000_000;   // Timing nominal
  localparam int unsigned TIM_STEP_HZ   = 109_000;      // Timing step
  localparam int unsigned CONV_FAST_HZ  = 1_000_000;    // Fast converter
  localparam int unsigned CONV_SLOW_HZ  = 500_000;      // Slow converter

  //============================================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  addr;   // Register address
    logic [15:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } stc_req_s;

  typedef struct packed {
    logic samp_tick;     // Sampling clock edge, gated
    logic tim_tick;      // Timing clock edge
    logic conv_tick;     // Converter clock edge
    logic sample_start;  // Internally paced sample start
  } stc_ticks_s;

  //============================================================================
  // Trimmed frequency from nominal, step and signed code offset
  function automatic logic [31:0] trim_freq(input logic [31:0] nom,
                                            input logic [31:0] step,
                                            input logic [7:0]  code,
                                            input logic [7:0]  centre,
                                            input logic        inverse);
    int delta;
    delta = inverse ? (int'(centre) - int'(code)) : (int'(code) - int'(centre));
    return 32'(int'(nom) + delta * int'(step));
  endfunction

endpackage

// File: sim/stc_clock_trim_sva.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// Port checker for the clock trim block
module stc_clock_trim_sva
  import stc_pkg::*;
(
  // Clock, reset and enable
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        clk_en,
  // Register port
  input wire stc_req_s    bus_req,
  input wire logic [15:0] rd_data,
  // Pin and outputs
  input wire logic        auxiliary_pin,
  input wire stc_ticks_s  ticks,
  input wire logic        sampling_clk,
  input wire logic        sampling_src_ext,
  input wire logic [15:0] conv_clock_code
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  //============================================================================
  // Decoded accesses that the block takes
  logic wr_samp;  // Write to sampling config
  logic wr_conv;  // Write to converter select
  logic rd_samp;  // Read of sampling config
  logic rd_conv;  // Read of converter select
  assign wr_samp = bus_req.wr && clk_en && bus_req.addr == OFS_SAMP_CFG;
  assign wr_conv = bus_req.wr && clk_en && bus_req.addr == OFS_CONV_SEL;
  assign rd_samp = bus_req.rd && clk_en && bus_req.addr == OFS_SAMP_CFG;
  assign rd_conv = bus_req.rd && clk_en && bus_req.addr == OFS_CONV_SEL;

  // Shadow of the sampling enable bit
  logic en_q;
  logic en_d;
  always_comb begin
    en_d = en_q;
    if (!reset_n) begin
      en_d = RST_SAMP_CFG[BIT_SAMP_EN];
    end else if (wr_samp) begin
      en_d = bus_req.wdata[BIT_SAMP_EN];
    end
  end
  always_ff @(posedge clock) if (clk_en) en_q <= en_d;

  //============================================================================
  // Assertions
  a_bypass_write: assert property (
    wr_samp |=> sampling_src_ext == $past(bus_req.wdata[BIT_BYPASS]))
    else $error("bypass level differs from written bit");
  a_bypass_read: assert property (
    rd_samp |=> rd_data[BIT_BYPASS] == $past(sampling_src_ext))
    else $error("bypass bit read back differs from level");
  a_ext_edge_tick: assert property (
    $rose(auxiliary_pin) && sampling_src_ext && en_q && clk_en |=> ticks.samp_tick)
    else $error("no sampling edge in the cycle after pin rose");
  a_gate_quiet: assert property (
    !en_q [*2] |-> !ticks.samp_tick && !sampling_clk)
    else $error("sampling clock active while disabled");
  a_tick_toggles: assert property (
    $rose(ticks.samp_tick) |-> sampling_clk != $past(sampling_clk))
    else $error("sampling clock did not toggle on edge");
  a_conv_write: assert property (
    wr_conv |=> conv_clock_code == $past(bus_req.wdata))
    else $error("converter code differs from written value");
  a_conv_steady: assert property (
    !wr_conv |=> $stable(conv_clock_code))
    else $error("converter code changed without a write");
  a_conv_read: assert property (
    rd_conv |=> rd_data == $past(conv_clock_code))
    else $error("converter code read back wrong");
  a_start_paced: assert property (
    ticks.sample_start && $past(clk_en) |-> $past(ticks.samp_tick))
    else $error("sample start without a sampling edge before it");
  a_read_idle: assert property (
    !bus_req.rd && clk_en |=> rd_data == 16'h0000)
    else $error("read data not zero outside a read");
  c_ext_edge: cover property (
    $rose(auxiliary_pin) && sampling_src_ext && en_q);
endmodule

bind stc_clock_trim stc_clock_trim_sva u_sva (
  .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .bus_req(bus_req),
  .rd_data(rd_data), .auxiliary_pin(auxiliary_pin), .ticks(ticks),
  .sampling_clk(sampling_clk), .sampling_src_ext(sampling_src_ext),
  .conv_clock_code(conv_clock_code)
);
`default_nettype wire

// File: sim/test_stc_clock_trim.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// Self-checking bench for the clock trim block
module test_stc_clock_trim
  import stc_pkg::*;
;
  localparam int WD = 80000;  // Watchdog span in cycles
  logic        clock, reset_n, clk_en, pin, sampling_clk, src_ext;
  stc_req_s    req;
  stc_ticks_s  ticks;
  logic [15:0] rd_data, conv_code;
  int          cnt [4];  // Edge counts: sampling, timing, converter, start
  int          bad_count, checks_done, g, s0, s3, f;
  logic [7:0]  ra [6] = '{OFS_SAMP_CFG, OFS_TIM_TRIM, OFS_CONV_SEL, OFS_TRIG_CFG,
                          OFS_SAMPLE_RATE, OFS_STATUS};
  logic [15:0] rv [6] = '{16'h2612, 16'h425E, 16'h0060, 16'h2090, 16'h0140, 16'h0008};
  logic [15:0] cc [3] = '{16'h0060, 16'h0040, 16'h0060};
  int          cf [3] = '{CONV_SLOW_HZ, CONV_FAST_HZ, CONV_SLOW_HZ};
  logic [7:0]  tc [3] = '{8'h00, 8'h5E, 8'hFF};
  logic [5:0]  sc [3] = '{6'h00, 6'h22, 6'h3F};

  stc_clock_trim uut (
    .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .bus_req(req),
    .rd_data(rd_data), .auxiliary_pin(pin), .ticks(ticks),
    .sampling_clk(sampling_clk), .sampling_src_ext(src_ext), .conv_clock_code(conv_code)
  );

  //============================================================================
  // Clock, edge counters and watchdog
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (ticks[3-i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end
  initial begin
    repeat (WD) @(posedge clock);
    bad_count++;
    print_verdict();
  end

  //============================================================================
  // Tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Rate measurements allow one count of quantisation
  task automatic approx(input int seen, input int exp);
    check((seen >= exp - 1 && seen <= exp + 1) ? exp : seen, exp);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Write: waits one edge if a write strobe is still being dropped
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    if (req.wr === 1'b1) @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  // Read: data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    check(rd_data, e);
    @(posedge clock);
  endtask
  // Cycles between two successive edges of one tick kind
  task automatic gap(input int sel, output int n);
    int c0;
    int t0;
    n = 0;
    c0 = cnt[sel];
    while (cnt[sel] == c0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    c0 = cnt[sel];
    t0 = n;
    while (cnt[sel] == c0 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    n = n - t0;
  endtask
  // Pin pulses, four cycles high, one per thousand cycles
  task automatic pulses;
    repeat (4) begin
      pin <= 1'b1;
      cycles(4);
      pin <= 1'b0;
      cycles(996);
    end
  endtask

  //============================================================================
  // Main sequence
  initial begin
    req = '0;
    pin = 1'b0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    cycles(10);
    reset_n <= 1'b1;
    cycles(1);
    check(src_ext, 1'b0);
    check(sampling_clk, 1'b0);
    check(conv_code, 16'h0060);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(OFS_STATUS, 16'hFFFF);
    rd(OFS_STATUS, 16'h0008);
    wr(8'h33, 16'hFFFF);
    rd(8'h33, 16'h0000);
    // Converter rates, defined codes only
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CONV_SEL, cc[i]);
      rd(OFS_CONV_SEL, cc[i]);
      check(conv_code, cc[i]);
      gap(2, g);
      approx(g, CLK_HZ / cf[i]);
    end
    // Request lost while the clock enable is low
    clk_en <= 1'b0;
    wr(OFS_CONV_SEL, 16'h0040);
    clk_en <= 1'b1;
    rd(OFS_CONV_SEL, 16'h0060);
    // Timing oscillator edges over 2500 cycles
    for (int i = 0; i < 3; i++) begin
      wr(OFS_TIM_TRIM, {8'h42, tc[i]});
      rd(OFS_TIM_TRIM, {8'h42, tc[i]});
      s0 = cnt[1];
      cycles(2500);
      f = int'(TIM_NOM_HZ) + (int'(tc[i]) - int'(TIM_CENTRE)) * int'(TIM_STEP_HZ);
      approx(cnt[1] - s0, f / 50000);
    end
    // Sampling oscillator period per trim code
    for (int i = 0; i < 3; i++) begin
      wr(OFS_SAMP_CFG, 16'h2680 | 16'(sc[i]));
      rd(OFS_SAMP_CFG, 16'h2680 | 16'(sc[i]));
      gap(0, g);
      f = int'(SAMP_NOM_HZ) + (int'(SAMP_CENTRE) - int'(sc[i])) * int'(SAMP_STEP_HZ);
      approx(g, CLK_HZ / f);
    end
    // Pin clock with internal pacing every second edge
    wr(OFS_TRIG_CFG, 16'h2094);
    wr(OFS_SAMPLE_RATE, 16'h0002);
    wr(OFS_SAMP_CFG, 16'h2780);
    wr(OFS_TRIG_CFG, 16'h2090);
    check(src_ext, 1'b1);
    s0 = cnt[0];
    s3 = cnt[3];
    pulses();
    check(cnt[0] - s0, 4);
    check(cnt[3] - s3, 2);
    // Other trigger select: no paced starts
    wr(OFS_TRIG_CFG, 16'h2094);
    s3 = cnt[3];
    pulses();
    check(cnt[3] - s3, 0);
    // Pin clock with the sampling clock disabled
    wr(OFS_SAMP_CFG, 16'h2700);
    s0 = cnt[0];
    pulses();
    check(cnt[0] - s0, 0);
    check(sampling_clk, 1'b0);
    // Reset in mid-run restores defaults
    wr(OFS_CONV_SEL, 16'h0040);
    reset_n <= 1'b0;
    cycles(2);
    reset_n <= 1'b1;
    cycles(1);
    rd(OFS_CONV_SEL, 16'h0060);
    check(src_ext, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
